// file: rtl/itwea_top.sv
// Purpose: AXI4-Lite register bank for indirect forwarding-table reads and wake-event access.
// Assumes: The table engine answers each request with one i_tbl_ack pulse.
// Notes: Registers are bytes in lane 0 of aligned words; upper bits read zero.
//
// Summary of operation
// - Writing the address register starts the read when select bits 4:2 are 110 and the code is not 100; low index bits.
// - Select register low bits give the high index bits.
// - Nine data bytes present the entry; the first holds bits 71 to 64.
// - Data bytes descend one per address; the last holds bits 7 to 0.
// - First two data bytes carry empty flag and valid-entry count.
// - Select code 100 picks wake-event access; port zero is global.
// - Port values one to three pick that port's wake-event registers.
// - Address register holds the byte offset; data moves through 0xA0.
// - Control and status bytes map most significant byte first.
// - Port mask occupies offsets 0x04 to 0x07, most significant first.
// - The selected location is readable and writable through 0xA0.
// - Magic packet status bit 2 sets on detection, clears by one.
// - Link-up status bit 1 sets on detection.
// - Energy status bit 0 sets on detection, clears by one.
// - Enable field zero disables the wake output.
// - Control bit 0 sets wake output polarity, one is active-high.
// - Entry bit 71 flags empty; bits 70:61 hold count minus one.
// - Entry bits 58:56 give the learning source port.
// - Entry bits 54:48 filter ident, 47:0 station address, 60:59 age.
//
// Local design decision: the AXI4-Lite interface to the registers.
module itwea_top
  import itwea_pkg::*;
#(
  parameter int NUM_PORTS = 3
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // AXI4-Lite write address and data
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [11:0] i_axi_awaddr,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  // AXI4-Lite write response
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  output logic [1:0] o_axi_bresp,
  // AXI4-Lite read
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  input wire logic [11:0] i_axi_araddr,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  // Forwarding table engine
  output logic o_tbl_req,
  output logic [TBL_INDEX_W-1:0] o_tbl_index,
  input wire logic i_tbl_ack,
  input wire logic i_tbl_empty,
  input wire logic [ENTRY_COUNT_W-1:0] i_tbl_count_m1,
  input wire logic [ENTRY_LOW_W-1:0] i_tbl_entry,
  // Wake-event detection, one bit per port
  input wire logic [NUM_PORTS-1:0] i_magic_det,
  input wire logic [NUM_PORTS-1:0] i_link_up_det,
  input wire logic [NUM_PORTS-1:0] i_energy_det,
  // Wake output pin
  output logic o_wake
);

  itwea_state_s r_reg;
  itwea_state_s r_next;
  logic [NUM_PORTS-1:0] port_wr;
  logic [STAT_W-1:0] port_status [NUM_PORTS];
  logic [31:0] port_mask [NUM_PORTS];
  logic [NUM_PORTS-1:0] port_hit;
  logic wr_go;
  logic ar_hs;
  logic [IDX_W-1:0] ar_idx;
  logic wake_active;
  logic dyn_sel;
  logic wake_sel;
  logic [3:0] sel_port;

  assign wake_sel = r_reg.sel_ctrl[SEL_CODE_MSB:SEL_CODE_LSB] == SEL_WAKE_CODE;
  assign dyn_sel = r_reg.sel_ctrl[SEL_OP_MSB:SEL_OP_LSB] == SEL_DYN_READ
                   && !wake_sel;
  assign sel_port = r_reg.sel_ctrl[SEL_PORT_MSB:0];
  assign wr_go = r_reg.aw_held && r_reg.w_held && !r_reg.bvalid;
  assign ar_hs = i_axi_arvalid && r_reg.arready;
  assign ar_idx = i_axi_araddr[ADDR_LSB +: IDX_W];

  // Byte seen through the window for the current select and offset.
  function automatic logic [7:0] window_byte(input logic [31:0] word, input logic [7:0] off);
    window_byte = word[8*(3-off[1:0]) +: 8];
  endfunction

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      assign port_hit[gp] = wake_sel && sel_port == 4'(gp + 1);
      assign port_wr[gp] = wr_go && r_reg.w_lane0 && port_hit[gp]
                           && r_reg.aw_idx == IDX_BYTE_WINDOW;
      itwea_port_regs u_port (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_wr_en(port_wr[gp]),
        .i_wr_off(r_reg.addr_trig),
        .i_wr_data(r_reg.w_byte),
        .i_events({i_magic_det[gp], i_link_up_det[gp], i_energy_det[gp]}),
        .o_status(port_status[gp]),
        .o_mask(port_mask[gp])
      );
    end
  endgenerate

  always_comb begin
    wake_active = 1'b0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      wake_active = wake_active | (|(port_status[p] & port_mask[p][STAT_W-1:0]));
    end
  end

  always_comb begin
    logic [7:0] rbyte;
    logic mapped;
    logic [ENTRY_W-1:0] view;
    logic [IDX_W-1:0] k;
    rbyte = RST_BYTE;
    mapped = 1'b1;
    view = r_reg.entry;
    k = '0;
    r_next = r_reg;

    // Write address and data are taken in either order and held until used.
    if (i_axi_awvalid && r_reg.awready) begin
      r_next.aw_held = 1'b1;
      r_next.awready = 1'b0;
      r_next.aw_idx = i_axi_awaddr[ADDR_LSB +: IDX_W];
    end
    if (i_axi_wvalid && r_reg.wready) begin
      r_next.w_held = 1'b1;
      r_next.wready = 1'b0;
      r_next.w_byte = i_axi_wdata[7:0];
      r_next.w_lane0 = i_axi_wstrb[0];
    end
    if (!r_reg.aw_held && !r_reg.bvalid && !(i_axi_awvalid && r_reg.awready)) begin
      r_next.awready = 1'b1;
    end
    if (!r_reg.w_held && !r_reg.bvalid && !(i_axi_wvalid && r_reg.wready)) begin
      r_next.wready = 1'b1;
    end

    // entry capture
    // Taken ahead of the write decode, so a trigger in the ack cycle restarts the fetch.
    if (r_reg.tbl_req && i_tbl_ack) begin
      r_next.tbl_req = 1'b0;
      r_next.pending = 1'b0;
      r_next.entry = {i_tbl_empty, i_tbl_count_m1, i_tbl_entry};
    end

    if (wr_go) begin
      r_next.aw_held = 1'b0;
      r_next.w_held = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = RESP_OKAY;
      unique case (r_reg.aw_idx)
        IDX_SELECT_CTRL: begin
          if (r_reg.w_lane0) begin
            r_next.sel_ctrl = r_reg.w_byte;
          end
        end
        IDX_ADDR_TRIG: begin
          if (r_reg.w_lane0) begin
            r_next.addr_trig = r_reg.w_byte;
            if (dyn_sel) begin
              r_next.pending = 1'b1;
              r_next.tbl_req = 1'b1;
            end
          end
        end
        IDX_BYTE_WINDOW: begin
          // global write keeps only defined bits
          if (r_reg.w_lane0 && wake_sel && sel_port == PORT_GLOBAL
              && r_reg.addr_trig == OFF_CTRL_LAST) begin
            r_next.gctrl = r_reg.w_byte[GCTRL_W-1:0];
          end
        end
        default: begin
          if (!(r_reg.aw_idx >= IDX_DATA_FIRST && r_reg.aw_idx <= IDX_DATA_LAST)) begin
            r_next.bresp = RESP_SLVERR;
          end
        end
      endcase
    end else if (r_reg.bvalid && i_axi_bready) begin
      r_next.bvalid = 1'b0;
    end

    if (r_reg.pending) begin
      view[ENTRY_BUSY_BIT] = 1'b1;
    end

    if (ar_idx == IDX_SELECT_CTRL) begin
      rbyte = r_reg.sel_ctrl;
    end else if (ar_idx == IDX_ADDR_TRIG) begin
      rbyte = r_reg.addr_trig;
    end else if (ar_idx >= IDX_DATA_FIRST && ar_idx <= IDX_DATA_LAST) begin
      k = ar_idx - IDX_DATA_FIRST;
      rbyte = view[ENTRY_W-1-8*k -: 8];
    end else if (ar_idx == IDX_BYTE_WINDOW) begin
      if (wake_sel && sel_port == PORT_GLOBAL && r_reg.addr_trig <= OFF_CTRL_LAST) begin
        rbyte = window_byte({30'h0000_0000, r_reg.gctrl}, r_reg.addr_trig);
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (port_hit[p] && r_reg.addr_trig <= OFF_CTRL_LAST) begin
          rbyte = window_byte({29'h0000_0000, port_status[p]}, r_reg.addr_trig);
        end else if (port_hit[p] && r_reg.addr_trig >= OFF_MASK_FIRST
                     && r_reg.addr_trig <= OFF_MASK_LAST) begin
          rbyte = window_byte(port_mask[p], r_reg.addr_trig);
        end
      end
    end else begin
      mapped = 1'b0;
    end

    // One read at a time: arready stays low until the answer is taken.
    if (ar_hs) begin
      r_next.arready = 1'b0;
      r_next.rvalid = 1'b1;
      r_next.rdata = {24'h00_0000, rbyte};
      r_next.rresp = mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (r_reg.rvalid && i_axi_rready) begin
      r_next.rvalid = 1'b0;
      r_next.arready = 1'b1;
    end else if (!r_reg.rvalid) begin
      r_next.arready = 1'b1;
    end

    // A disabled pin rests at its inactive level; the pin is never released.
    // wake pin level
    if (r_reg.gctrl[GCTRL_EN_BIT]) begin
      r_next.wake = wake_active ~^ r_reg.gctrl[GCTRL_POL_BIT];
    end else begin
      r_next.wake = ~r_reg.gctrl[GCTRL_POL_BIT];
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_axi_awready = r_reg.awready;
  assign o_axi_wready = r_reg.wready;
  assign o_axi_bvalid = r_reg.bvalid;
  assign o_axi_bresp = r_reg.bresp;
  assign o_axi_arready = r_reg.arready;
  assign o_axi_rvalid = r_reg.rvalid;
  assign o_axi_rdata = r_reg.rdata;
  assign o_axi_rresp = r_reg.rresp;
  assign o_tbl_req = r_reg.tbl_req;
  // The index follows the registers, so rewriting them mid-fetch moves the request.
  // high index bits
  assign o_tbl_index = {r_reg.sel_ctrl[SEL_HIGH_IDX_MSB:0], r_reg.addr_trig};
  assign o_wake = r_reg.wake;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  sequence trig_write_s;
    wr_go && r_reg.aw_idx == IDX_ADDR_TRIG && r_reg.w_lane0 && dyn_sel;
  endsequence
  sequence fetch_busy_s;
    o_tbl_req && r_reg.pending;
  endsequence
  sequence window_read_s;
    ar_hs && ar_idx == IDX_BYTE_WINDOW;
  endsequence

  trigger_starts_read_a: assert property (trig_write_s |=> fetch_busy_s)
    else $error("address write did not start a table read");
  index_high_bits_a: assert property (
    trig_write_s |=> o_tbl_index == {$past(r_reg.sel_ctrl[1:0]), $past(r_reg.w_byte)})
    else $error("table index not built from select and address");
  entry_capture_a: assert property (
    o_tbl_req && i_tbl_ack |=> r_reg.entry[ENTRY_EMPTY_BIT] == $past(i_tbl_empty)
    && r_reg.entry[ENTRY_LOW_W-1:0] == $past(i_tbl_entry)
    && (!o_tbl_req || $past(wr_go && r_reg.aw_idx == IDX_ADDR_TRIG)))
    else $error("table answer not captured");
  first_byte_a: assert property (
    ar_hs && ar_idx == IDX_DATA_FIRST
    |=> o_axi_rvalid && o_axi_rdata[7:0] == $past(r_reg.entry[ENTRY_W-1 -: 8]))
    else $error("first data byte is not bits 71 to 64");
  last_byte_a: assert property (
    ar_hs && ar_idx == IDX_DATA_LAST && !r_reg.pending
    |=> o_axi_rdata[7:0] == $past(r_reg.entry[7:0]))
    else $error("last data byte is not bits 7 to 0");
  busy_reads_one_a: assert property (
    ar_hs && ar_idx == IDX_DATA_READY && r_reg.pending |=> o_axi_rdata[7])
    else $error("ready flag clear while fetch pending");
  global_reserved_a: assert property (
    ar_hs && ar_idx == IDX_BYTE_WINDOW && wake_sel && sel_port == PORT_GLOBAL
    && r_reg.addr_trig < OFF_CTRL_LAST |=> o_axi_rdata == RST_WORD)
    else $error("reserved global byte not zero");
  wake_disabled_a: assert property (
    !r_reg.gctrl[GCTRL_EN_BIT] |=> o_wake == !$past(r_reg.gctrl[GCTRL_POL_BIT]))
    else $error("wake pin active while disabled");
  wake_polarity_a: assert property (
    r_reg.gctrl[GCTRL_EN_BIT] && r_reg.gctrl[GCTRL_POL_BIT] && wake_active |=> o_wake)
    else $error("active-high wake pin not driven high");
  wake_active_low_a: assert property (
    r_reg.gctrl[GCTRL_EN_BIT] && !r_reg.gctrl[GCTRL_POL_BIT] && wake_active |=> !o_wake)
    else $error("active-low wake pin not driven low");
  wake_no_fetch_a: assert property (
    wr_go && r_reg.aw_idx == IDX_ADDR_TRIG && wake_sel && !r_reg.tbl_req |=> !o_tbl_req)
    else $error("offset write under the wake code started a table read");
  global_write_a: assert property (
    wr_go && r_reg.w_lane0 && r_reg.aw_idx == IDX_BYTE_WINDOW && wake_sel
    && sel_port == PORT_GLOBAL && r_reg.addr_trig == OFF_CTRL_LAST
    |=> r_reg.gctrl == $past(r_reg.w_byte[GCTRL_W-1:0]))
    else $error("global control byte not stored");
  port_status_read_a: assert property (
    window_read_s ##0 port_hit[0] && r_reg.addr_trig == OFF_CTRL_LAST
    |=> o_axi_rdata == {29'h0000_0000, $past(port_status[0])})
    else $error("port status not in the low byte");
  mask_first_byte_a: assert property (
    window_read_s ##0 port_hit[0] && r_reg.addr_trig == OFF_MASK_FIRST
    |=> o_axi_rdata[7:0] == $past(port_mask[0][31:24]))
    else $error("mask offset four is not the top byte");
  write_answer_a: assert property (wr_go |=> o_axi_bvalid [*1] ##0 !r_reg.aw_held)
    else $error("write response missing after address and data");
  read_answer_a: assert property (ar_hs |=> o_axi_rvalid && !o_axi_arready)
    else $error("read answer missing after the address");

endmodule // itwea_top

// file: rtl/itwea_pkg.sv
// Purpose: Shared constants and types for the indirect table and wake-event access block.
// Assumes: Register index times four is the byte address on the host bus.
// Notes: Wake-event registers are internal and only reached through the byte window.
package itwea_pkg;

  // Register indices on the host bus; byte address is four times the index.
  localparam logic [7:0] IDX_SELECT_CTRL = 8'h6e;
  localparam logic [7:0] IDX_ADDR_TRIG = 8'h6f;
  localparam logic [7:0] IDX_DATA_FIRST = 8'h70;
  localparam logic [7:0] IDX_DATA_LAST = 8'h78;
  localparam logic [7:0] IDX_DATA_READY = 8'h72;
  localparam logic [7:0] IDX_BYTE_WINDOW = 8'ha0;
  localparam int ADDR_LSB = 2;
  localparam int IDX_W = 8;

  // Select register fields.
  localparam logic [2:0] SEL_WAKE_CODE = 3'h4;
  localparam logic [2:0] SEL_DYN_READ = 3'h6;
  localparam int SEL_CODE_MSB = 7;
  localparam int SEL_CODE_LSB = 5;
  localparam int SEL_OP_MSB = 4;
  localparam int SEL_OP_LSB = 2;
  localparam int SEL_PORT_MSB = 3;
  localparam int SEL_HIGH_IDX_MSB = 1;
  localparam logic [3:0] PORT_GLOBAL = 4'h0;

  // Wake-event byte offsets inside the window.
  localparam logic [7:0] OFF_CTRL_LAST = 8'h03;
  localparam logic [7:0] OFF_MASK_FIRST = 8'h04;
  localparam logic [7:0] OFF_MASK_LAST = 8'h07;

  // Forwarding entry layout.
  localparam int ENTRY_W = 72;
  localparam int ENTRY_EMPTY_BIT = 71;
  localparam int ENTRY_COUNT_W = 10;
  localparam int ENTRY_LOW_W = 61;
  localparam int ENTRY_BUSY_BIT = 55;
  localparam int TBL_INDEX_W = 10;

  // Wake-event bit positions.
  localparam int GCTRL_POL_BIT = 0;
  localparam int GCTRL_EN_BIT = 1;
  localparam int GCTRL_W = 2;
  localparam int STAT_ENERGY_BIT = 0;
  localparam int STAT_LINK_BIT = 1;
  localparam int STAT_MAGIC_BIT = 2;
  localparam int STAT_W = 3;

  // Bus responses and reset values.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // State of one port's wake-event register set.
  typedef struct packed {
    logic [STAT_W-1:0] status;
    logic [31:0] mask;
  } itwea_port_s;

  // State of the top block.
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_held;
    logic w_held;
    logic [IDX_W-1:0] aw_idx;
    logic [7:0] w_byte;
    logic w_lane0;
    logic [7:0] sel_ctrl;
    logic [7:0] addr_trig;
    logic [ENTRY_W-1:0] entry;
    logic pending;
    logic tbl_req;
    logic [GCTRL_W-1:0] gctrl;
    logic wake;
  } itwea_state_s;

endpackage

// file: rtl/itwea_port_regs.sv
// Purpose: One port's wake-event status and mask registers behind the byte window.
// Assumes: Event inputs are one-cycle pulses synchronous to i_sys_clk.
// Notes: A detected event in the clearing cycle wins over the write of one.
module itwea_port_regs
  import itwea_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Byte write from the window
  input wire logic i_wr_en,
  input wire logic [7:0] i_wr_off,
  input wire logic [7:0] i_wr_data,
  // Detected events
  input wire logic [STAT_W-1:0] i_events,
  // Register contents
  output logic [STAT_W-1:0] o_status,
  output logic [31:0] o_mask
);

  itwea_port_s st_reg;
  itwea_port_s st_next;
  logic [STAT_W-1:0] clr;
  logic [1:0] lane;

  always_comb begin
    st_next = st_reg;
    clr = '0;
    lane = i_wr_off[1:0];
    if (i_wr_en && i_wr_off == OFF_CTRL_LAST) begin
      clr = i_wr_data[STAT_W-1:0];
    end
    if (i_wr_en && i_wr_off >= OFF_MASK_FIRST && i_wr_off <= OFF_MASK_LAST) begin
      st_next.mask[8*(3-lane) +: 8] = i_wr_data;
    end
    st_next.status = (st_reg.status & ~clr) | i_events;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_status = st_reg.status;
  assign o_mask = st_reg.mask;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  energy_set_a: assert property (i_events[STAT_ENERGY_BIT] |=> o_status[STAT_ENERGY_BIT])
    else $error("energy event did not set status");
  magic_clear_a: assert property (
    i_wr_en && i_wr_off == OFF_CTRL_LAST && i_wr_data[STAT_MAGIC_BIT]
    && !i_events[STAT_MAGIC_BIT] |=> !o_status[STAT_MAGIC_BIT])
    else $error("magic status not cleared by write of one");
  link_hold_a: assert property (
    o_status[STAT_LINK_BIT] && !i_wr_en |=> o_status[STAT_LINK_BIT])
    else $error("link status lost without clear");

endmodule // itwea_port_regs

// file: verification/tb_indirect_table_wake_event_access.sv
// Purpose: Self-checking bench for the indirect table and wake-event register bank.
// Assumes: Byte address on the bus is four times the register index.
// Notes: Table entries and mask bytes at offsets 4 to 6 are random; the bench keeps its own copy.
module tb_indirect_table_wake_event_access
  import itwea_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic [11:0] aw_a = 12'h000, ar_a = 12'h000;
  logic [31:0] w_d = 32'h0000_0000;
  logic [3:0] w_s = 4'h0;
  logic t_ack = 1'b0, t_empty = 1'b0;
  logic [9:0] t_cnt = 10'h000;
  logic [60:0] t_ent = '0;
  logic [2:0] magic = 3'h0, link = 3'h0, energy = 3'h0;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, t_req, wake;
  logic [1:0] b_resp, r_resp, resp;
  logic [31:0] r_d, rd;
  logic [9:0] t_idx;
  logic [71:0] ent;
  logic [7:0] m;
  logic [7:0] mask [1:3][4:7];
  int mismatches = 0;
  int n_checks = 0;

  itwea_top #(.NUM_PORTS(3)) u_dut (
    .i_sys_clk(clk), .i_rst(rst),
    .i_axi_awvalid(aw_v), .o_axi_awready(aw_rdy), .i_axi_awaddr(aw_a),
    .i_axi_wvalid(w_v), .o_axi_wready(w_rdy), .i_axi_wdata(w_d), .i_axi_wstrb(w_s),
    .o_axi_bvalid(b_v), .i_axi_bready(b_r), .o_axi_bresp(b_resp),
    .i_axi_arvalid(ar_v), .o_axi_arready(ar_rdy), .i_axi_araddr(ar_a),
    .o_axi_rvalid(r_v), .i_axi_rready(r_r), .o_axi_rdata(r_d), .o_axi_rresp(r_resp),
    .o_tbl_req(t_req), .o_tbl_index(t_idx), .i_tbl_ack(t_ack), .i_tbl_empty(t_empty),
    .i_tbl_count_m1(t_cnt), .i_tbl_entry(t_ent),
    .i_magic_det(magic), .i_link_up_det(link), .i_energy_det(energy),
    .o_wake(wake)
  );

  always #25 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // A wait that used up its bound ends the run as a failure.
  task automatic tmo(input int i);
    if (i >= 64) begin
      mismatches++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int i;
    @(posedge clk);
    aw_v <= 1'b1;
    aw_a <= a;
    w_v <= 1'b1;
    w_d <= {24'h0, d};
    w_s <= 4'h1;
    b_r <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge clk);
      if (aw_rdy) aw_v <= 1'b0;
      if (w_rdy) w_v <= 1'b0;
      if (b_v) break;
    end
    tmo(i);
    resp = b_resp;
    b_r <= 1'b0;
  endtask

  task automatic rdb(input logic [11:0] a);
    int i;
    @(posedge clk);
    ar_v <= 1'b1;
    ar_a <= a;
    r_r <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge clk);
      if (ar_rdy) ar_v <= 1'b0;
      if (r_v) break;
    end
    tmo(i);
    rd = r_d;
    resp = r_resp;
    r_r <= 1'b0;
  endtask

  // Points the byte window at one wake-event location.
  task automatic wsel(input logic [7:0] sel, input logic [7:0] off);
    wr(12'h1b8, sel);
    wr(12'h1bc, off);
  endtask

  initial begin
    void'($urandom(32'hbd03));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(wake), 32'h1);
    for (int k = 0; k < 2; k++) begin
      m = (k == 1) ? 8'h19 : 8'h18;
      wr(12'h1b8, m);
      wr(12'h1bc, 8'(k));
      chk(32'(resp), 32'(RESP_OKAY));
      chk(32'(t_req), 32'h1);
      chk(32'(t_idx), {22'h0, m[1:0], 8'(k)});
      rdb(12'h1c8);
      chk(32'(rd[7]), 32'h1);
      ent = {8'($urandom()), 32'($urandom()), 32'($urandom())};
      ent[55] = 1'b0;
      t_empty <= ent[71];
      t_cnt <= ent[70:61];
      t_ent <= ent[60:0];
      t_ack <= 1'b1;
      @(posedge clk);
      t_ack <= 1'b0;
      @(posedge clk);
      chk(32'(t_req), 32'h0);
      for (int i = 0; i < 9; i++) begin
        rdb(12'h1c0 + 12'(4 * i));
        chk(rd, {24'h0, ent[71 - 8 * i -: 8]});
        chk(32'(resp), 32'(RESP_OKAY));
      end
    end
    for (int o = 0; o < 4; o++) begin
      wsel(8'h80, 8'(o));
      wr(12'h280, 8'hff);
      rdb(12'h280);
      chk(rd, (o == 3) ? 32'h3 : 32'h0);
    end
    repeat (2) @(posedge clk);
    chk(32'(wake), 32'h0);
    for (int p = 1; p < 4; p++) begin
      for (int o = 4; o < 8; o++) begin
        m = 8'($urandom());
        if (o == 7) m = (p == 1) ? 8'h04 : 8'h00;
        mask[p][o] = m;
        wsel(8'h80 | 8'(p), 8'(o));
        wr(12'h280, m);
      end
    end
    for (int p = 1; p < 4; p++) begin
      for (int o = 4; o < 8; o++) begin
        wsel(8'h80 | 8'(p), 8'(o));
        rdb(12'h280);
        chk(rd, {24'h0, mask[p][o]});
      end
    end
    @(posedge clk);
    magic <= 3'h1;
    link <= 3'h2;
    energy <= 3'h4;
    @(posedge clk);
    magic <= 3'h0;
    link <= 3'h0;
    energy <= 3'h0;
    repeat (3) @(posedge clk);
    chk(32'(wake), 32'h1);
    for (int p = 1; p < 4; p++) begin
      wsel(8'h80 | 8'(p), 8'h03);
      rdb(12'h280);
      chk(rd, 32'h8 >> p);
      wr(12'h280, 8'hff);
      rdb(12'h280);
      chk(rd, 32'h0);
    end
    repeat (2) @(posedge clk);
    chk(32'(wake), 32'h0);
    // Active-low output, then disabled output.
    wsel(8'h80, 8'h03);
    wr(12'h280, 8'h02);
    repeat (2) @(posedge clk);
    chk(32'(wake), 32'h1);
    magic <= 3'h1;
    @(posedge clk);
    magic <= 3'h0;
    repeat (3) @(posedge clk);
    chk(32'(wake), 32'h0);
    wr(12'h280, 8'h00);
    repeat (2) @(posedge clk);
    chk(32'(wake), 32'h1);
    rdb(12'h004);
    chk(32'(resp), 32'(RESP_SLVERR));
    wr(12'h004, 8'h5a);
    chk(32'(resp), 32'(RESP_SLVERR));
    complete_run();
  end

endmodule // tb_indirect_table_wake_event_access
